//--- hdl/kwsr_pkg.sv
/*
 * Constants for the key wakeup stop release block: register offsets,
 * field positions, reset values and the warm-up count.
 * Assumes a 25 MHz system clock and a 16-bit register address.
 */
package kwsr_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [15:0] KEY_WAKE_ENABLE_OFS = 16'h0F9A;
  localparam logic [15:0] SYSTEM_CONTROL_1_OFS = 16'h0F38;
  localparam logic [15:0] WAKE_STATUS_OFS = 16'h0F9B;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int KEY_EN_LSB = 4;
  localparam int SYS_STOP_BIT = 7;
  localparam int SYS_RELM_BIT = 6;
  localparam int ST_STOP_BIT = 7;
  localparam int ST_WARM_BIT = 6;
  localparam int ST_RELM_BIT = 5;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [3:0] KEY_EN_RST = 4'h0;
  localparam logic RELM_RST = 1'b1;
  localparam logic [4:0] PIN_IDLE = 5'h1E;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int WARMUP_TIME_NS = 2000;
  localparam int WARMUP_CYC = (WARMUP_TIME_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
  localparam logic [7:0] WARMUP_LAST = 8'(WARMUP_CYC - 1);

  typedef enum logic [1:0] {
    KWSR_RUN,
    KWSR_STOP,
    KWSR_WARM
  } kwsr_state_t;

endpackage : kwsr_pkg

//--- hdl/kwsr_top.sv
/*
 * Key wakeup stop release: ends stop mode from the stop-release pin or
 * from four individually enabled key wake pins in level mode, then runs warm-up.
 * Assumes pins are asynchronous and a plain one-cycle register port.
 */
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Stop pin plus four key pins release
// - One enable bit per key pin
// - Enables in bits 7..4, write-only
// - Stop entered by write; enabled low releases
// - Wake pending at entry skips to warm-up
// - Level mode levels; edge mode rising stop
module kwsr_top (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESETN,
  // Register port
  input wire logic [15:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Wake pins
  input wire logic STOP_PIN,
  input wire logic [3:0] KEY_WAKE_PIN,
  // Power state
  output logic OSC_HALT,
  output logic WARMUP
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Bit 0 is the stop-release pin, bits 4..1 key wake pins 2..5
  logic [4:0] pin_raw;
  logic [4:0] s1_ff;
  logic [4:0] s2_ff;
  logic [4:0] s3_ff;
  logic [4:0] lvl_ff;

  assign pin_raw = {KEY_WAKE_PIN, STOP_PIN};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
      always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
          s1_ff[gi] <= kwsr_pkg::PIN_IDLE[gi];
          s2_ff[gi] <= kwsr_pkg::PIN_IDLE[gi];
          s3_ff[gi] <= kwsr_pkg::PIN_IDLE[gi];
          lvl_ff[gi] <= kwsr_pkg::PIN_IDLE[gi];
        end else begin
          s1_ff[gi] <= pin_raw[gi];
          s2_ff[gi] <= s1_ff[gi];
          s3_ff[gi] <= s2_ff[gi];
          // Glitch shorter than a cycle never reaches the level
          if (s2_ff[gi] == s3_ff[gi]) begin
            lvl_ff[gi] <= s3_ff[gi];
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // Register decode
  // ****************************************
  logic [3:0] key_en_ff;
  logic relm_ff;
  logic stop_prev_ff;
  logic [7:0] cnt_ff;
  kwsr_pkg::kwsr_state_t state_ff;
  kwsr_pkg::kwsr_state_t nxt_state;
  logic [7:0] nxt_cnt;
  logic [7:0] nxt_rdata;

  wire hit_en = (ADDR == kwsr_pkg::KEY_WAKE_ENABLE_OFS);
  wire hit_sys = (ADDR == kwsr_pkg::SYSTEM_CONTROL_1_OFS);
  wire hit_st = (ADDR == kwsr_pkg::WAKE_STATUS_OFS);
  wire wr_en = WR & hit_en;
  wire wr_sys = WR & hit_sys;
  wire stop_req = wr_sys & WDATA[kwsr_pkg::SYS_STOP_BIT];

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      key_en_ff <= kwsr_pkg::KEY_EN_RST;
      relm_ff <= kwsr_pkg::RELM_RST;
    end else begin
      if (wr_en) begin
        key_en_ff <= WDATA[7:4];
      end
      if (wr_sys) begin
        relm_ff <= WDATA[kwsr_pkg::SYS_RELM_BIT];
      end
    end
  end

  // ****************************************
  // Wake detection
  // ****************************************
  // Held as pure logic so no extra clock edge is spent deciding
  wire [3:0] key_low = key_en_ff & ~lvl_ff[4:1];
  wire wake_level = lvl_ff[0] | (|key_low);
  wire wake_edge = lvl_ff[0] & ~stop_prev_ff;
  wire wake_now = relm_ff ? wake_level : wake_edge;
  wire in_stop = (state_ff == kwsr_pkg::KWSR_STOP);
  wire release_stop = in_stop & wake_now;
  // Level check at entry applies in both release modes
  wire skip_stop = wake_level;

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      stop_prev_ff <= 1'b0;
    end else begin
      stop_prev_ff <= lvl_ff[0];
    end
  end

  // ****************************************
  // Stop and warm-up sequence
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      kwsr_pkg::KWSR_RUN: begin
        if (stop_req) begin
          nxt_cnt = kwsr_pkg::WARMUP_LAST;
          nxt_state = skip_stop ? kwsr_pkg::KWSR_WARM
                                : kwsr_pkg::KWSR_STOP;
        end
      end
      kwsr_pkg::KWSR_STOP: begin
        if (release_stop) begin
          nxt_cnt = kwsr_pkg::WARMUP_LAST;
          nxt_state = kwsr_pkg::KWSR_WARM;
        end
      end
      kwsr_pkg::KWSR_WARM: begin
        if (cnt_ff == 8'h00) begin
          nxt_state = kwsr_pkg::KWSR_RUN;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      default: begin
        nxt_state = kwsr_pkg::KWSR_RUN;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      state_ff <= kwsr_pkg::KWSR_RUN;
      cnt_ff <= 8'h00;
      OSC_HALT <= 1'b0;
      WARMUP <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      OSC_HALT <= (nxt_state == kwsr_pkg::KWSR_STOP);
      WARMUP <= (nxt_state == kwsr_pkg::KWSR_WARM);
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  // Enable register is write-only, so its address reads zero
  wire [7:0] rd_sys = {1'b0, relm_ff, 6'h00};
  wire [7:0] rd_st = {in_stop, (state_ff == kwsr_pkg::KWSR_WARM),
                      relm_ff, lvl_ff};

  always_comb begin
    nxt_rdata = 8'h00;
    if (RD & hit_sys) begin
      nxt_rdata = rd_sys;
    end else if (RD & hit_st) begin
      nxt_rdata = rd_st;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= nxt_rdata;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  a_en_write_upper: assert property (
    wr_en |=> key_en_ff == $past(WDATA[7:4]))
    else $error("key enable not loaded from upper nibble");

  a_en_read_zero: assert property (
    (RD & hit_en) |=> RDATA == 8'h00)
    else $error("write-only enable register read nonzero");

  a_stop_entry: assert property (
    (state_ff == kwsr_pkg::KWSR_RUN && stop_req && !skip_stop)
      |=> OSC_HALT && !WARMUP)
    else $error("stop not entered on control write");

  a_skip_stop: assert property (
    (state_ff == kwsr_pkg::KWSR_RUN && stop_req && skip_stop)
      |=> WARMUP && !OSC_HALT)
    else $error("pending wake did not skip stop");

  a_key_release: assert property (
    (in_stop && relm_ff && !lvl_ff[0] && key_en_ff[0] && !lvl_ff[1])
      |=> WARMUP)
    else $error("enabled key low failed to release");

  // One release check per key wake pin
  genvar gk;
  generate
    for (gk = 0; gk < 4; gk = gk + 1) begin : g_key_chk
      a_key_pin_wake: assert property (
        (in_stop && relm_ff && key_en_ff[gk] && !lvl_ff[gk + 1])
          |=> WARMUP && !OSC_HALT)
        else $error("enabled key pin low did not release stop");
    end
  endgenerate

  a_key_blocked: assert property (
    (in_stop && !lvl_ff[0] && (key_en_ff & ~lvl_ff[4:1]) == 4'h0)
      |=> OSC_HALT)
    else $error("disabled key pins released stop");

  a_edge_keys_dead: assert property (
    (in_stop && !relm_ff && !wake_edge) |=> OSC_HALT)
    else $error("edge mode released without rising stop pin");

  a_edge_release: assert property (
    (in_stop && !relm_ff && lvl_ff[0] && !stop_prev_ff) |=> WARMUP)
    else $error("rising stop pin did not release");

  a_warm_length: assert property (
    $rose(WARMUP) |-> WARMUP [*8])
    else $error("warm-up ended too early");

  a_warm_ends: assert property (
    $rose(WARMUP) |-> ##[1:60] !WARMUP)
    else $error("warm-up never ended");

  a_sync_filter: assert property (
    (s2_ff[0] != s3_ff[0]) |=> lvl_ff[0] == $past(lvl_ff[0]))
    else $error("unstable pin changed filtered level");

  // Warm-up cycles counted so the full length can be checked
  logic [7:0] warm_seen_ff;
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      warm_seen_ff <= 8'h00;
    end else if (WARMUP) begin
      warm_seen_ff <= warm_seen_ff + 8'h01;
    end else begin
      warm_seen_ff <= 8'h00;
    end
  end

  a_warm_exact: assert property (
    $fell(WARMUP) |-> warm_seen_ff == 8'(kwsr_pkg::WARMUP_CYC))
    else $error("warm-up length differs from the set count");

  a_rdata_idle: assert property (
    !RD |=> RDATA == 8'h00)
    else $error("read data not zero outside a read");

  a_relm_write: assert property (
    wr_sys |=> relm_ff == $past(WDATA[kwsr_pkg::SYS_RELM_BIT]))
    else $error("release mode not loaded from control write");

  a_release_warm: assert property (
    $fell(OSC_HALT) |-> WARMUP)
    else $error("stop left without starting warm-up");

  a_run_no_halt: assert property (
    (state_ff == kwsr_pkg::KWSR_RUN && !stop_req) |=> !OSC_HALT)
    else $error("stop entered without a control write");

  a_status_stop: assert property (
    (RD && hit_st && in_stop) |=> RDATA[kwsr_pkg::ST_STOP_BIT])
    else $error("status read missed stop mode");

  c_key_wake: cover property (in_stop && relm_ff && |key_low ##1 WARMUP);
  c_edge_wake: cover property (in_stop && !relm_ff && wake_edge);
  c_skip: cover property (state_ff == kwsr_pkg::KWSR_RUN && stop_req
                          && skip_stop);
  c_full_cycle: cover property ($fell(WARMUP) ##1 !OSC_HALT);

endmodule : kwsr_top

`default_nettype wire

//--- sim/kwsr_keys.sv
/* Model of the keys and the release switch on the wake pins.
   Assumes the bench commands each press; idle keys read high. */
`timescale 1ns/1ps
`default_nettype none
module kwsr_keys (
  // Commands
  input wire logic [3:0] press,
  input wire logic stop_hi,
  // Pins
  output logic [3:0] key_pin,
  output logic stop_pin
);
  // Released keys float to the pull-up level
  assign key_pin = ~press;
  // Held low unless a release is commanded
  assign stop_pin = stop_hi;
endmodule : kwsr_keys
`default_nettype wire

//--- sim/kwsr_top_tb.sv
/* Self-checking bench for the key wakeup stop release block.
   Assumes the key model in kwsr_keys and a 25 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module kwsr_top_tb;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] press = 4'h0;
  logic stop_hi = 1'b0;
  wire logic [7:0] rdata;
  wire logic [3:0] key_pin;
  wire logic stop_pin;
  wire logic osc_halt;
  wire logic warmup;
  int error_cnt = 0;
  int n_compared = 0;
  initial forever #20 clk_sys = ~clk_sys;
  kwsr_keys keys (.press(press), .stop_hi(stop_hi), .key_pin(key_pin),
    .stop_pin(stop_pin));
  kwsr_top dut (.CLK_SYS(clk_sys), .RESETN(resetn), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .STOP_PIN(stop_pin),
    .KEY_WAKE_PIN(key_pin), .OSC_HALT(osc_halt), .WARMUP(warmup));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr_reg(logic [15:0] a, logic [7:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_reg(string nm, logic [15:0] a, logic [7:0] exp);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 chk(nm, rdata, exp);
  endtask : rd_reg
  task automatic pins(logic [3:0] p, logic s);
    @(posedge clk_sys);
    press <= p;
    stop_hi <= s;
    #1;
  endtask : pins
  task automatic quiet(string nm);
    repeat (10) @(posedge clk_sys);
    #1 chk(nm, {6'h00, osc_halt, warmup}, 8'h02);
  endtask : quiet
  // Waits for warm-up, then times how long it stands
  task automatic wake_seen(string nm);
    int n;
    n = 0;
    while (warmup !== 1'b1 && n < 12) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk(nm, {6'h00, osc_halt, warmup}, 8'h01);
    n = 0;
    while (warmup === 1'b1 && n < 80) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk("warm_len", 8'(n), 8'(kwsr_pkg::WARMUP_CYC));
  endtask : wake_seen
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    chk("state_rst", {6'h00, osc_halt, warmup}, 8'h00);
    rd_reg("status_rst", 16'h0F9B, 8'h3E);
    wr_reg(16'h0F9A, 8'hF0);
    rd_reg("enable_wo", 16'h0F9A, 8'h00);
    rd_reg("unmapped", 16'h0F00, 8'h00);
  endtask : t_reset
  task automatic t_keys;
    for (int i = 0; i < 4; i++) begin
      wr_reg(16'h0F9A, 8'(8'h10 << i));
      wr_reg(16'h0F38, 8'hC0);
      chk("enter", {6'h00, osc_halt, warmup}, 8'h02);
      rd_reg("status_stop", 16'h0F9B, 8'hBE);
      pins(~(4'h1 << i), 1'b0);
      quiet("disabled_key");
      pins(4'hF, 1'b0);
      wake_seen("key_wake");
      pins(4'h0, 1'b0);
      repeat (6) @(posedge clk_sys);
    end
  endtask : t_keys
  task automatic t_skip;
    wr_reg(16'h0F9A, 8'hF0);
    pins(4'h8, 1'b0);
    repeat (6) @(posedge clk_sys);
    wr_reg(16'h0F38, 8'hC0);
    chk("skip_key", {6'h00, osc_halt, warmup}, 8'h01);
    // Pins held until warm-up ends so its full length is timed
    wake_seen("skip_key_end");
    pins(4'h0, 1'b1);
    repeat (6) @(posedge clk_sys);
    wr_reg(16'h0F38, 8'hC0);
    chk("skip_stop", {6'h00, osc_halt, warmup}, 8'h01);
    wake_seen("skip_stop_end");
    pins(4'h0, 1'b0);
    repeat (6) @(posedge clk_sys);
    wr_reg(16'h0F38, 8'hC0);
    chk("enter_lvl", {6'h00, osc_halt, warmup}, 8'h02);
    pins(4'h0, 1'b1);
    wake_seen("stop_level");
    pins(4'h0, 1'b0);
    repeat (6) @(posedge clk_sys);
  endtask : t_skip
  // Keys pressed in edge mode on purpose: they must be ignored
  task automatic t_edge;
    wr_reg(16'h0F38, 8'h00);
    rd_reg("status_edge", 16'h0F9B, 8'h1E);
    wr_reg(16'h0F38, 8'h80);
    pins(4'hF, 1'b0);
    quiet("edge_keys");
    pins(4'h0, 1'b0);
    quiet("edge_idle");
    pins(4'h0, 1'b1);
    wake_seen("edge_rise");
    pins(4'h0, 1'b0);
  endtask : t_edge
  // ****************************************
  // Run control
  // ****************************************
  task automatic close_out;
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    #1;
    t_reset();
    t_keys();
    t_skip();
    t_edge();
    close_out();
  end
  // About five times the expected run
  initial begin
    repeat (3000) @(posedge clk_sys);
    error_cnt++;
    close_out();
  end
endmodule : kwsr_top_tb
`default_nettype wire
